// ### logic/fgr_pkg.sv
// Constants shared by the fine-granularity refresh controller.
// Assumes a 50 MHz mclk and a 4Gb device on the far side.
package fgr_pkg;
  localparam int CLK_MHZ = 50;
  // Base interval in nanoseconds (7.8 us)
  localparam int REFI_BASE_NS = 7800;
  localparam int RFC1_NS = 260;
  localparam int RFC2_NS = 160;
  localparam int RFC4_NS = 110;
  localparam int REFI1_CYC = (REFI_BASE_NS * CLK_MHZ) / 1000;
  localparam int REFI2_CYC = (REFI_BASE_NS / 2 * CLK_MHZ) / 1000;
  localparam int REFI4_CYC = (REFI_BASE_NS / 4 * CLK_MHZ) / 1000;
  localparam int RFC1_CYC = (RFC1_NS * CLK_MHZ + 999) / 1000;
  localparam int RFC2_CYC = (RFC2_NS * CLK_MHZ + 999) / 1000;
  localparam int RFC4_CYC = (RFC4_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 9;
  localparam int CMD_W = 5;
  // Rate field encodings
  localparam logic [2:0] MODE_FIX1 = 3'h0;
  localparam logic [2:0] MODE_FIX2 = 3'h1;
  localparam logic [2:0] MODE_FIX4 = 3'h2;
  localparam logic [2:0] MODE_OTF12 = 3'h5;
  localparam logic [2:0] MODE_OTF14 = 3'h6;
  // Mode register addressing
  localparam logic [1:0] CFG_REG_SEL = 2'h3;
  localparam logic [1:0] FEAT_REG_SEL = 2'h0;
  localparam int RATE_LSB = 6;
  localparam int TCR_BIT = 3;
  localparam int ADDR_W = 14;
  // Command pins {cs_n, act_n, ras_n, cas_n, we_n}
  localparam logic [4:0] CMD_DES = 5'h1F;
  localparam logic [4:0] CMD_REF = 5'h09;
  localparam logic [4:0] CMD_MRW = 5'h08;
  typedef enum logic [1:0] {FGR_RATE1, FGR_RATE2, FGR_RATE4} fgr_rate_t;
endpackage

// ### logic/fgr_wait_timer.sv
// Down counter that holds a busy level for a loaded number of cycles.
// Assumes the loader only loads when the timer is idle.
`timescale 1ns/1ps
module fgr_wait_timer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic load,
  input wire logic [fgr_pkg::CNT_W-1:0] count,
  output logic busy
);
  logic [fgr_pkg::CNT_W-1:0] remain;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      remain <= '0;
    end else if (load) begin
      remain <= count;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      // Same as remain above one, without widening the compare to 32 bits
      busy <= load || (remain[fgr_pkg::CNT_W-1:1] != '0);
    end
  end
endmodule

// ### logic/fgr_refresh_host.sv
// Host-side refresh scheduler for a device with fine-granularity refresh.
// Assumes the device samples the command pins on mclk and needs no reset.
`timescale 1ns/1ps
// What this block does
// RULE1 - Rate field codes 000,001,010 fixed; 101,110 per-command; rest reserved.
// RULE2 - Program a per-command mode by mode write before relying on it.
// RULE3 - In per-command modes BG0 low gives single rate, high faster rate.
// RULE4 - Refresh is cs low, act high, ras low, cas low, we high.
// RULE5 - Interval base 7.8 us; halved for double, quartered for quad.
// RULE6 - Cycle time 260, 160, 110 ns for single, double, quad refresh.
// RULE7 - Each mode permits only refreshes of its own allowed rates.
// RULE8 - New interval and cycle time apply from the rate change onward.
// RULE9 - Even double-rate count before another rate-changing mode write.
// RULE10 - Even double-rate count between two single-rate refreshes.
// RULE11 - Quad-rate count multiple of four before change or single refresh.
// RULE12 - Fixed single has no counting; same-rate fixed/per-command is no change.
// RULE13 - Temperature compensation only while rate field is 000.
// RULE14 - Self refresh entry allowed in any mode regardless of count.
// RULE15 - Odd double count at entry needs one single or two doubles after.
// RULE16 - Quad count not multiple of four needs one single or four quads.
// RULE17 - Extra post-exit refreshes do not count toward the interval.
// RULE18 - Feature register bit 3 switches temperature compensation.
// RULE19 - At most 8, 16 or 32 refreshes may be postponed per mode.
// RULE20 - Only deselects until the cycle time of a refresh has passed.
// RULE21 - Never program reserved rate field encodings.
module fgr_refresh_host (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] req_mode,
  input wire logic req_tcr,
  input wire logic req_fast,
  input wire logic sr_exit,
  output logic cs_n,
  output logic act_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] bg,
  output logic [fgr_pkg::ADDR_W-1:0] addr,
  output logic mode_busy,
  output logic sr_ready,
  output logic [2:0] cur_mode,
  output logic owe_refresh
);
  typedef enum logic [2:0] {
    FGR_ST_IDLE, FGR_ST_TCR_OFF, FGR_ST_RATE, FGR_ST_TCR_ON, FGR_ST_WAIT
  } fgr_state_t;

  fgr_state_t state;
  logic [12:0] interval;
  logic [2:0] parity;
  logic [2:0] extra;
  logic [5:0] owed;
  logic tcr_on;
  logic rfc_busy;
  logic rfc_load;
  logic [fgr_pkg::CNT_W-1:0] rfc_count;
  logic next_fast;
  logic issue_ref;
  logic issue_mrw;
  logic cfg_ok;
  logic rate_change;
  logic parity_ok;
  fgr_pkg::fgr_rate_t next_rate;
  logic [12:0] next_interval;
  logic [2:0] next_parity;
  logic [5:0] owed_max;

  fgr_wait_timer u_rfc (
    .mclk(mclk),
    .rst(rst),
    .load(rfc_load),
    .count(rfc_count),
    .busy(rfc_busy)
  );

  // RULE1 RULE21 legal codes
  always_comb begin
    cfg_ok = (req_mode == fgr_pkg::MODE_FIX1) || (req_mode == fgr_pkg::MODE_FIX2) ||
             (req_mode == fgr_pkg::MODE_FIX4) || (req_mode == fgr_pkg::MODE_OTF12) ||
             (req_mode == fgr_pkg::MODE_OTF14);
  end

  // RULE12 rate-equal switch
  always_comb begin
    rate_change = (req_mode[1:0] != cur_mode[1:0]) &&
                  !(req_mode[1:0] != 2'h0 && cur_mode[1:0] != 2'h0 &&
                    req_mode[1:0] == cur_mode[1:0]);
  end

  // RULE9 RULE11 whole groups
  always_comb begin
    parity_ok = (parity == 3'h0);
  end

  // RULE7 RULE3 rate pick
  always_comb begin
    next_fast = 1'b0;
    unique case (cur_mode)
      fgr_pkg::MODE_FIX2: next_fast = 1'b1;
      fgr_pkg::MODE_FIX4: next_fast = 1'b1;
      fgr_pkg::MODE_OTF12: next_fast = req_fast || (parity != 3'h0) || (extra != 3'h0);
      fgr_pkg::MODE_OTF14: next_fast = req_fast || (parity != 3'h0) || (extra != 3'h0);
      default: next_fast = 1'b0;
    endcase
    if (!next_fast) begin
      next_rate = fgr_pkg::FGR_RATE1;
    end else if (cur_mode[1]) begin
      next_rate = fgr_pkg::FGR_RATE4;
    end else begin
      next_rate = fgr_pkg::FGR_RATE2;
    end
  end

  // RULE5 RULE6 RULE8 per-rate timing
  always_comb begin
    unique case (next_rate)
      fgr_pkg::FGR_RATE2: begin
        next_interval = 13'(fgr_pkg::REFI2_CYC);
        rfc_count = fgr_pkg::CNT_W'(fgr_pkg::RFC2_CYC);
        owed_max = 6'h10;
        next_parity = 3'(parity + 3'h1) & 3'h1;
      end
      fgr_pkg::FGR_RATE4: begin
        next_interval = 13'(fgr_pkg::REFI4_CYC);
        rfc_count = fgr_pkg::CNT_W'(fgr_pkg::RFC4_CYC);
        owed_max = 6'h20;
        next_parity = 3'(parity + 3'h1) & 3'h3;
      end
      default: begin
        next_interval = 13'(fgr_pkg::REFI1_CYC);
        rfc_count = fgr_pkg::CNT_W'(fgr_pkg::RFC1_CYC);
        owed_max = 6'h08;
        next_parity = 3'h0;
      end
    endcase
  end

  // RULE20 deselect hold
  always_comb begin
    // Held off on the exit edge so the group restart never loses a refresh
    issue_ref = (state == FGR_ST_IDLE) && !rfc_busy && !sr_exit &&
                ((owed != 6'h0) || (extra != 3'h0));
    issue_mrw = (state inside {FGR_ST_TCR_OFF, FGR_ST_RATE, FGR_ST_TCR_ON}) && !rfc_busy;
    rfc_load = issue_ref || issue_mrw;
  end

  // RULE2 RULE13 write order
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= FGR_ST_IDLE;
    end else begin
      unique case (state)
        FGR_ST_IDLE: begin
          // Compare against the gated request, else a refused enable loops forever
          if (!issue_ref && cfg_ok &&
              (req_mode != cur_mode ||
               (req_tcr && req_mode == fgr_pkg::MODE_FIX1) != tcr_on) &&
              (!rate_change || parity_ok)) begin
            state <= FGR_ST_TCR_OFF;
          end
        end
        FGR_ST_TCR_OFF: if (issue_mrw) state <= FGR_ST_RATE;
        FGR_ST_RATE: if (issue_mrw) state <= FGR_ST_TCR_ON;
        FGR_ST_TCR_ON: if (issue_mrw) state <= FGR_ST_WAIT;
        FGR_ST_WAIT: if (!rfc_busy) state <= FGR_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_mode <= fgr_pkg::MODE_FIX1;
      tcr_on <= 1'b0;
    end else if (issue_mrw && state == FGR_ST_RATE) begin
      cur_mode <= req_mode;
    end else if (issue_mrw && state == FGR_ST_TCR_ON) begin
      // RULE13 RULE18 compensation gate
      tcr_on <= req_tcr && (cur_mode == fgr_pkg::MODE_FIX1);
    end else if (issue_mrw && state == FGR_ST_TCR_OFF) begin
      tcr_on <= 1'b0;
    end
  end

  // RULE5 RULE17 interval debt
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      interval <= 13'(fgr_pkg::REFI1_CYC - 1);
      owed <= 6'h0;
    end else begin
      // Counts N-1 down to 0 so one interval spans exactly N cycles
      if (interval == 13'h0) begin
        interval <= next_interval - 13'h1;
      end else begin
        interval <= interval - 13'h1;
      end
      // RULE19 postpone cap
      if (interval == 13'h0 && !(issue_ref && extra == 3'h0) && owed < owed_max) begin
        owed <= owed + 6'h1;
      end else if (issue_ref && extra == 3'h0 && interval != 13'h0) begin
        owed <= owed - 6'h1;
      end
    end
  end

  // RULE10 RULE11 RULE14 RULE15 RULE16 group count
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      parity <= 3'h0;
      extra <= 3'h0;
    end else if (sr_exit) begin
      if (parity != 3'h0) begin
        extra <= cur_mode[1] ? 3'h4 : 3'h2;
      end
      parity <= 3'h0;
    end else if (issue_ref) begin
      parity <= next_parity;
      if (extra != 3'h0) begin
        extra <= extra - 3'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sr_ready <= 1'b1;
      mode_busy <= 1'b0;
      owe_refresh <= 1'b0;
    end else begin
      // RULE14 entry allowed in any mode and at any count, once idle and not busy
      sr_ready <= !rfc_busy && !rfc_load && (state == FGR_ST_IDLE);
      mode_busy <= (state != FGR_ST_IDLE);
      owe_refresh <= (owed != 6'h0) || (extra != 3'h0);
    end
  end

  // RULE4 command drive
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {cs_n, act_n, ras_n, cas_n, we_n} <= fgr_pkg::CMD_DES;
      bg <= 2'h0;
      addr <= '0;
    end else if (issue_ref) begin
      {cs_n, act_n, ras_n, cas_n, we_n} <= fgr_pkg::CMD_REF;
      // RULE3 rate on bank group
      bg <= {1'b0, next_fast && cur_mode[2]};
      addr <= '0;
    end else if (issue_mrw) begin
      {cs_n, act_n, ras_n, cas_n, we_n} <= fgr_pkg::CMD_MRW;
      bg <= (state == FGR_ST_RATE) ? fgr_pkg::CFG_REG_SEL : fgr_pkg::FEAT_REG_SEL;
      addr <= '0;
      if (state == FGR_ST_RATE) begin
        addr[fgr_pkg::RATE_LSB +: 3] <= req_mode;
      end else if (state == FGR_ST_TCR_ON) begin
        addr[fgr_pkg::TCR_BIT] <= req_tcr && (cur_mode == fgr_pkg::MODE_FIX1);
      end
    end else begin
      {cs_n, act_n, ras_n, cas_n, we_n} <= fgr_pkg::CMD_DES;
      bg <= 2'h0;
      addr <= '0;
    end
  end

  // RULE20 deselect after refresh
  chk_des_after_ref: assert property (@(posedge mclk) disable iff (rst)
    ($fell(cas_n) && we_n) |=> (cs_n [*5])) else $error("command inside refresh cycle time");

  // RULE4 refresh encoding
  chk_ref_encode: assert property (@(posedge mclk) disable iff (rst)
    (!cs_n && !cas_n && we_n) |-> (act_n && !ras_n)) else $error("bad refresh encoding");

  // RULE13 compensation only in fixed single
  chk_tcr_mode: assert property (@(posedge mclk) disable iff (rst)
    tcr_on |-> (cur_mode == fgr_pkg::MODE_FIX1)) else $error("compensation in wrong mode");

  // RULE21 no reserved code
  chk_rate_legal: assert property (@(posedge mclk) disable iff (rst)
    (!cs_n && !we_n && bg == fgr_pkg::CFG_REG_SEL) |->
      addr[fgr_pkg::RATE_LSB +: 3] inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6})
    else $error("reserved rate code written");

  // RULE7 fixed modes use no BG0 marker
  chk_fixed_bg: assert property (@(posedge mclk) disable iff (rst)
    (!cs_n && !cas_n && we_n && !cur_mode[2]) |-> (bg == 2'h0)) else $error("bg0 set in fixed mode");

  // RULE15 extra count after exit
  chk_extra_load: assert property (@(posedge mclk) disable iff (rst)
    (sr_exit && parity != 3'h0 && !cur_mode[1]) |=> (extra == 3'h2)) else $error("extra not loaded");

  // RULE9 parity clean before rate write
  chk_parity_change: assert property (@(posedge mclk) disable iff (rst)
    ($rose(mode_busy) && rate_change) |-> $past(parity) == 3'h0) else $error("rate change mid group");

  // RULE19 postpone cap
  chk_owed_cap: assert property (@(posedge mclk) disable iff (rst)
    owed <= 6'h20) else $error("postpone debt over cap");

  // Thirteen deselects cover the single-rate cycle time
  sequence fgr_single_gap;
    cs_n [*8] ##1 cs_n [*5];
  endsequence

  // RULE6 RULE20 single-rate cycle time
  chk_single_gap: assert property (@(posedge mclk) disable iff (rst)
    (!cs_n && !cas_n && we_n &&
     (cur_mode == fgr_pkg::MODE_FIX1 || (cur_mode[2] && !bg[0])))
      |=> fgr_single_gap) else $error("single refresh cycle time cut short");

  // RULE16 quad extras after exit
  chk_extra_quad: assert property (@(posedge mclk) disable iff (rst)
    (sr_exit && parity != 3'h0 && cur_mode[1]) |=> (extra == 3'h4))
    else $error("quad extras not loaded");

  // RULE10 RULE11 single only on whole group
  chk_single_whole: assert property (@(posedge mclk) disable iff (rst)
    (!cs_n && !cas_n && we_n && cur_mode[2] && !bg[0]) |-> ($past(parity) == 3'h0))
    else $error("single refresh inside fast group");
endmodule

// ### dv/fgr_dev_model.sv
// Behavioural model of the refresh side of the device: decodes commands and flags misuse.
// Assumes the command pins are sampled on rising mclk; the device has no reset.
`timescale 1ns/1ps
module fgr_dev_model (
  input wire logic mclk,
  input wire logic cs_n,
  input wire logic act_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bg,
  input wire logic [fgr_pkg::ADDR_W-1:0] addr,
  input wire logic sr_exit,
  output logic pend,
  output logic [2:0] mode,
  output logic temp_compensated_refresh,
  output logic [1:0] grp,
  output logic [15:0] refs,
  output logic [7:0] viol
);
  logic [4:0] cmd;
  logic [3:0] hold;
  logic [1:0] g;
  fgr_pkg::fgr_rate_t rate;
  int v;
  assign cmd = {cs_n, act_n, ras_n, cas_n, we_n};
  function automatic fgr_pkg::fgr_rate_t cls(input logic [2:0] c);
    if (c == fgr_pkg::MODE_FIX2 || c == fgr_pkg::MODE_OTF12) return fgr_pkg::FGR_RATE2;
    if (c == fgr_pkg::MODE_FIX4 || c == fgr_pkg::MODE_OTF14) return fgr_pkg::FGR_RATE4;
    return fgr_pkg::FGR_RATE1;
  endfunction
  always_comb begin
    rate = cls(mode);
    if ((mode == fgr_pkg::MODE_OTF12 || mode == fgr_pkg::MODE_OTF14) && !bg[0]) begin
      rate = fgr_pkg::FGR_RATE1;
    end
  end
  initial begin
    mode = 3'h0;
    temp_compensated_refresh = 1'b0;
    grp = 2'h0;
    refs = 16'h0;
    viol = 8'h0;
    hold = 4'h0;
    pend = 1'b0;
  end
  always @(posedge mclk) begin
    v = 0;
    g = grp;
    if (hold != 0) hold <= hold - 4'h1;
    if (cmd !== fgr_pkg::CMD_DES && hold != 0) v++;
    if (cmd === fgr_pkg::CMD_REF) begin
      refs <= refs + 16'h1;
      hold <= (rate == fgr_pkg::FGR_RATE1) ? 4'(fgr_pkg::RFC1_CYC - 1) :
              (rate == fgr_pkg::FGR_RATE2) ? 4'(fgr_pkg::RFC2_CYC - 1) :
              4'(fgr_pkg::RFC4_CYC - 1);
      if (rate == fgr_pkg::FGR_RATE1) begin
        if (g != 0) v++;
        pend <= 1'b0;
      end else begin
        g = (g + 2'h1) & ((rate == fgr_pkg::FGR_RATE2) ? 2'h1 : 2'h3);
        if (g == 2'h0) pend <= 1'b0;
      end
    end
    // exit restarts the group; a partial one owes extras
    if (sr_exit === 1'b1) begin
      pend <= (g != 2'h0);
      g = 2'h0;
    end
    grp <= g;
    if (cmd === fgr_pkg::CMD_MRW && bg === fgr_pkg::CFG_REG_SEL) begin
      if (!(addr[8:6] inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6})) v++;
      else if (cls(addr[8:6]) != cls(mode) && grp != 0) v++;
      mode <= addr[8:6];
    end
    if (cmd === fgr_pkg::CMD_MRW && bg === fgr_pkg::FEAT_REG_SEL) temp_compensated_refresh <= addr[fgr_pkg::TCR_BIT];
    if (temp_compensated_refresh && mode != 3'h0) v++;
    viol <= viol + 8'(v);
  end
endmodule

// ### dv/tb_top.sv
// Self-checking bench: tabled then random mode requests and random refresh-rate picks against the device model.
// Assumes a 50 MHz mclk; inputs change on the falling edge.
`timescale 1ns/1ps
module tb_top;
  logic mclk, rst, req_tcr, req_fast, sr_exit, cs_n, act_n, ras_n, cas_n, we_n;
  logic mode_busy, sr_ready, owe_refresh, dtcr, pend;
  logic [2:0] req_mode, cur_mode, dmode, want;
  logic [1:0] bg;
  logic [fgr_pkg::ADDR_W-1:0] addr;
  logic [15:0] refs;
  logic [7:0] viol;
  logic [2:0] codes [8] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5, 3'h7, 3'h0};
  int num_errors, checks, seed, n;
  fgr_refresh_host u_fgr_refresh_host (.mclk(mclk), .rst(rst), .req_mode(req_mode),
    .req_tcr(req_tcr), .req_fast(req_fast), .sr_exit(sr_exit), .cs_n(cs_n), .act_n(act_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bg(bg), .addr(addr), .mode_busy(mode_busy),
    .sr_ready(sr_ready), .cur_mode(cur_mode), .owe_refresh(owe_refresh));
  fgr_dev_model u_fgr_dev_model (.mclk(mclk), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bg(bg), .addr(addr), .sr_exit(sr_exit), .pend(pend),
    .mode(dmode), .temp_compensated_refresh(dtcr), .grp(),
    .refs(refs), .viol(viol));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic legal(input logic [2:0] c);
    return c inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
  endfunction
  function automatic int iv(input logic [2:0] c);
    if (c == 3'h1 || c == 3'h5) return fgr_pkg::REFI2_CYC;
    if (c == 3'h2 || c == 3'h6) return fgr_pkg::REFI4_CYC;
    return fgr_pkg::REFI1_CYC;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_range(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("wrong value at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic conclude;
    $display("num_errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic step(input logic [2:0] c);
    logic [2:0] exp;
    logic [15:0] r0;
    logic etcr;
    exp = legal(c) ? c : cur_mode;
    req_mode = c;
    // Code 000 always asks for compensation so the enable path is exercised
    req_tcr = (c == 3'h0) || 1'($random(seed));
    etcr = req_tcr && c == 3'h0;
    cyc(2);
    for (n = 0; (cur_mode !== exp || mode_busy !== 1'b0 || (legal(c) && dtcr !== etcr)) &&
         n < 3000; n++) cyc(1);
    cyc(2);
    cmp(16'(cur_mode), 16'(exp));
    cmp(16'(dmode), 16'(exp));
    if (legal(c)) cmp(16'(dtcr), 16'(req_tcr && c == 3'h0));
    r0 = refs;
    cyc(2340);
    if (exp > 3'h2) cmp_range(int'(refs - r0), 4, 2340 / iv(exp) + 2);
    else cmp_range(int'(refs - r0), 2340 / iv(exp) - 2, 2340 / iv(exp) + 2);
    // Exit with a possibly partial fast group must be squared up by extra refreshes
    sr_exit = 1'b1;
    cyc(1);
    sr_exit = 1'b0;
    for (n = 0; (pend !== 1'b0 || sr_ready !== 1'b1) && n < 1000; n++) cyc(1);
    cmp(16'({pend, sr_ready}), 16'h1);
  endtask
  initial begin
    // Eleven steps of at most about 6400 cycles each
    #(80000 * 20);
    num_errors++;
    conclude();
  end
  always @(negedge mclk) req_fast <= 1'($random(seed));
  initial begin
    seed = 32'hb48b8dad;
    num_errors = 0;
    checks = 0;
    rst = 1'b1;
    req_mode = 3'h0;
    req_tcr = 1'b0;
    req_fast = 1'b0;
    sr_exit = 1'b0;
    cyc(2);
    cmp(16'({cs_n, act_n, ras_n, cas_n, we_n, sr_ready, mode_busy, owe_refresh, cur_mode}),
        16'h07E0);
    rst = 1'b0;
    for (int i = 0; i < 11; i++) begin
      want = (i < 8) ? codes[i] : 3'($random(seed));
      step(want);
    end
    cmp(16'(viol), 16'h0);
    conclude();
  end
endmodule
